// ### logic/dpoc_regs.vh
// Register map, field layout, reset values and timing constants of the directional overcurrent block.
// Assumes a 250 MHz core clock and an APB slave with 32-bit data, one aligned word per register.
`ifndef DPOC_REGS_VH
`define DPOC_REGS_VH

// Register byte offsets.
`define DPOC_CTRL_ADDR 12'h000
`define DPOC_ANGLE_ADDR 12'h004
`define DPOC_START_ADDR 12'h008
`define DPOC_TMS_ADDR 12'h00c
`define DPOC_MIN_ADDR 12'h010
`define DPOC_DEF_ADDR 12'h014
`define DPOC_RST_ADDR 12'h018
`define DPOC_STAT_ADDR 12'h01c
`define DPOC_EVT_ADDR 12'h020
`define DPOC_SOTF_ADDR 12'h024

// Control field positions.
`define DPOC_OP_LSB 0
`define DPOC_OP_MSB 3
`define DPOC_DIR_LSB 4
`define DPOC_DIR_MSB 5
`define DPOC_VTND_BIT 6
`define DPOC_HZ60_BIT 7

// Operation codes.
`define DPOC_OP_OFF 4'h0
`define DPOC_OP_DT 4'h1
`define DPOC_OP_IEC_FIRST 4'h2
`define DPOC_OP_IEC_LAST 4'h5
`define DPOC_OP_LAST 4'hc

// Direction codes.
`define DPOC_DIR_NONDIR 2'h0
`define DPOC_DIR_FWD 2'h1
`define DPOC_DIR_BWD 2'h2

// Reset values.
`define DPOC_CTRL_RST 8'h10
`define DPOC_CHAR_RST 8'sh3c
`define DPOC_OPER_RST 7'h3c
`define DPOC_START_RST 12'h0c8
`define DPOC_TMS_RST 11'h064
`define DPOC_MIN_RST 16'h0064
`define DPOC_DEF_RST 16'h0064
`define DPOC_RSTT_RST 16'h0064
`define DPOC_SOTF_RST 16'h001e

// Setting limits.
`define DPOC_CHAR_MIN 8'sha6
`define DPOC_CHAR_MAX 8'sh5a
`define DPOC_OPER_MIN 7'h0a
`define DPOC_OPER_MAX 7'h55
`define DPOC_START_MIN 12'h00a
`define DPOC_START_MAX 12'hfa0
`define DPOC_TMS_MIN 11'h005
`define DPOC_TMS_MAX 11'h5dc
`define DPOC_MS_MIN 16'h001e
`define DPOC_RSTMS_MIN 16'h003c
`define DPOC_MS_MAX 16'hea60

// Timing.
`define DPOC_CLK_MHZ 250
`define DPOC_US_PER_MS 1000
`define DPOC_HYST_DEG 9'h00a
`define DPOC_MEM50_MS 8'h50
`define DPOC_MEM60_MS 8'h46

`endif

// ### logic/dpoc_core.v
// Directional three-phase overcurrent start and trip decision with an APB settings and status file.
// Assumes measurements and user-logic inputs are synchronous to core_clk_i and already scaled:
// currents in percent of rated, angles in whole degrees of voltage relative to current.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "dpoc_regs.vh"

module dpoc_core (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire [15:0] phase_a_current_i,
  input wire [15:0] phase_b_current_i,
  input wire [15:0] phase_c_current_i,
  input wire [8:0] loop_angle_i,
  input wire loop_valid_i,
  input wire volt_present_i,
  input wire function_block_in_i,
  input wire vt_failure_in_i,
  input wire switch_onto_fault_in_i,
  output reg phase_a_start_out_o,
  output reg phase_b_start_out_o,
  output reg phase_c_start_out_o,
  output reg general_start_out_o,
  output reg general_trip_out_o,
  output reg [4:0] event_o,
  output reg [4:0] event_value_o
);

  // Core cycles per millisecond tick. The product is an integer and is cut to the divider width on purpose.
  // The divider is fixed, so long delays cannot be shortened for simulation.
  localparam integer MS_CYCLES_FULL = `DPOC_CLK_MHZ * `DPOC_US_PER_MS;
  localparam [17:0] MS_CYCLES = MS_CYCLES_FULL[17:0];

  // Timer states, one-hot.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_TRIP = 3'b100;

  // Settings other than sotf_ms are held in clamped form, so the datapath never sees an illegal value from them.
  reg [7:0] ctrl;
  reg signed [7:0] char_angle;
  reg [6:0] oper_angle;
  reg [11:0] start_pct;
  reg [10:0] tms;
  reg [15:0] min_ms;
  reg [15:0] def_ms;
  reg [15:0] rst_ms;
  reg [15:0] sotf_ms;
  reg [4:0] evt_sticky;
  // Timing state: millisecond divider, trip timer and directional memory.
  reg [17:0] ms_div;
  reg ms_tick;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] accum;
  reg [15:0] decay_ms;
  reg in_sector;
  reg [7:0] mem_ms;
  reg [4:0] prev_out;

  // Control fields are decoded once; every mode decision below reads these.
  wire [3:0] op = ctrl[`DPOC_OP_MSB:`DPOC_OP_LSB];
  wire [1:0] dir = ctrl[`DPOC_DIR_MSB:`DPOC_DIR_LSB];
  wire vt_nondir = ctrl[`DPOC_VTND_BIT];
  wire hz60 = ctrl[`DPOC_HZ60_BIT];
  wire is_iec = (op >= `DPOC_OP_IEC_FIRST) && (op <= `DPOC_OP_IEC_LAST);

  // Clamp a millisecond setting to its legal range; shared by the minimum, definite-time and reset delay registers.
  function [15:0] clamp_ms;
    input [31:0] v;
    input [15:0] lo;
    begin
      if (v[31:16] != 16'h0000 || v[15:0] > `DPOC_MS_MAX) begin
        clamp_ms = `DPOC_MS_MAX;
      end else if (v[15:0] < lo) begin
        clamp_ms = lo;
      end else begin
        clamp_ms = v[15:0];
      end
    end
  endfunction

  // Angular distance between two degree values, folded into 0..180.
  // Folding keeps the wrap at 180 degrees from splitting a sector in two.
  function [8:0] ang_dist;
    input signed [9:0] a;
    input signed [9:0] b;
    reg signed [10:0] d;
    begin
      d = a - b;
      if (d > 11'sd180) begin
        d = d - 11'sd360;
      end else if (d < -11'sd180) begin
        d = d + 11'sd360;
      end
      if (d < 0) begin
        d = -d;
      end
      ang_dist = d[8:0];
    end
  endfunction

  // APB: zero wait states, never an error; unmapped reads give zero.
  // A write commits at the access edge; the read mux is combinational on the address.
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  wire apb_wr = psel_i && penable_i && pwrite_i;
  wire apb_rd = psel_i && penable_i && !pwrite_i;

  // Settings registers; out-of-range writes are clamped for every register but sotf_ms, which takes any 16-bit value.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= `DPOC_CTRL_RST;
      char_angle <= `DPOC_CHAR_RST;
      oper_angle <= `DPOC_OPER_RST;
      start_pct <= `DPOC_START_RST;
      tms <= `DPOC_TMS_RST;
      min_ms <= `DPOC_MIN_RST;
      def_ms <= `DPOC_DEF_RST;
      rst_ms <= `DPOC_RSTT_RST;
      sotf_ms <= `DPOC_SOTF_RST;
    end else if (apb_wr) begin
      case (paddr_i)
        `DPOC_CTRL_ADDR: begin
          ctrl <= pwdata_i[7:0];
          if (pwdata_i[`DPOC_OP_MSB:`DPOC_OP_LSB] > `DPOC_OP_LAST) begin
            ctrl[`DPOC_OP_MSB:`DPOC_OP_LSB] <= `DPOC_OP_OFF;
          end
        end
        `DPOC_ANGLE_ADDR: begin
          if ($signed(pwdata_i[7:0]) < `DPOC_CHAR_MIN) begin
            char_angle <= `DPOC_CHAR_MIN;
          end else if ($signed(pwdata_i[7:0]) > `DPOC_CHAR_MAX) begin
            char_angle <= `DPOC_CHAR_MAX;
          end else begin
            char_angle <= pwdata_i[7:0];
          end
          if (pwdata_i[14:8] < `DPOC_OPER_MIN) begin
            oper_angle <= `DPOC_OPER_MIN;
          end else if (pwdata_i[14:8] > `DPOC_OPER_MAX) begin
            oper_angle <= `DPOC_OPER_MAX;
          end else begin
            oper_angle <= pwdata_i[14:8];
          end
        end
        `DPOC_START_ADDR: begin
          if (pwdata_i[11:0] < `DPOC_START_MIN || pwdata_i[31:12] != 20'h00000) begin
            start_pct <= (pwdata_i[31:12] != 20'h00000) ? `DPOC_START_MAX : `DPOC_START_MIN;
          end else if (pwdata_i[11:0] > `DPOC_START_MAX) begin
            start_pct <= `DPOC_START_MAX;
          end else begin
            start_pct <= pwdata_i[11:0];
          end
        end
        `DPOC_TMS_ADDR: begin
          if (pwdata_i[10:0] < `DPOC_TMS_MIN) begin
            tms <= `DPOC_TMS_MIN;
          end else if (pwdata_i[10:0] > `DPOC_TMS_MAX || pwdata_i[31:11] != 21'h000000) begin
            tms <= `DPOC_TMS_MAX;
          end else begin
            tms <= pwdata_i[10:0];
          end
        end
        `DPOC_MIN_ADDR: min_ms <= clamp_ms(pwdata_i, `DPOC_MS_MIN);
        `DPOC_DEF_ADDR: def_ms <= clamp_ms(pwdata_i, `DPOC_MS_MIN);
        `DPOC_RST_ADDR: rst_ms <= clamp_ms(pwdata_i, `DPOC_RSTMS_MIN);
        // The high-speed delay has no floor, so software may ask for a trip on the next tick.
        `DPOC_SOTF_ADDR: sotf_ms <= pwdata_i[15:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; status shows live outputs, event register shows sticky change flags.
  always @* begin
    case (paddr_i)
      `DPOC_CTRL_ADDR: prdata_o = {24'h000000, ctrl};
      `DPOC_ANGLE_ADDR: prdata_o = {17'h00000, oper_angle, char_angle};
      `DPOC_START_ADDR: prdata_o = {20'h00000, start_pct};
      `DPOC_TMS_ADDR: prdata_o = {21'h000000, tms};
      `DPOC_MIN_ADDR: prdata_o = {16'h0000, min_ms};
      `DPOC_DEF_ADDR: prdata_o = {16'h0000, def_ms};
      `DPOC_RST_ADDR: prdata_o = {16'h0000, rst_ms};
      `DPOC_SOTF_ADDR: prdata_o = {16'h0000, sotf_ms};
      `DPOC_STAT_ADDR: prdata_o = {23'h000000, in_sector, mem_ms != 8'h00, 2'h0, prev_out};
      `DPOC_EVT_ADDR: prdata_o = {27'h0000000, evt_sticky};
      default: prdata_o = 32'h00000000;
    endcase
  end

  // Millisecond tick divider; all delay arithmetic runs in whole milliseconds.
  // The first tick after reset may come up to one millisecond late, which the delays absorb.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ms_div <= 18'h00000;
      ms_tick <= 1'b0;
    end else if (ms_div == MS_CYCLES - 18'h00001) begin
      ms_div <= 18'h00000;
      ms_tick <= 1'b1;
    end else begin
      ms_div <= ms_div + 18'h00001;
      ms_tick <= 1'b0;
    end
  end

  // Voltage memory: refreshed while voltage is present and the loop is valid, usable for a fixed span after that ends.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_ms <= 8'h00;
    end else if (volt_present_i && loop_valid_i) begin
      mem_ms <= hz60 ? `DPOC_MEM60_MS : `DPOC_MEM50_MS;
    end else if (ms_tick && mem_ms != 8'h00) begin
      mem_ms <= mem_ms - 8'h01;
    end
  end

  // Directional sector test. The loop angle is voltage relative to current, so it is positive for
  // an inductive forward fault. Backward mirrors the sector through the origin.
  // For a characteristic angle near zero the mirrored centre lies close to 180 degrees; the folded distance copes.
  wire signed [9:0] sect_centre = (dir == `DPOC_DIR_BWD) ?
    (char_angle > 0 ? {{2{char_angle[7]}}, char_angle} - 10'sd180 : {{2{char_angle[7]}}, char_angle} + 10'sd180) :
    {{2{char_angle[7]}}, char_angle};
  wire [8:0] sect_dist = ang_dist($signed({loop_angle_i[8], loop_angle_i}), sect_centre);
  wire angle_usable = loop_valid_i && (volt_present_i || mem_ms != 8'h00);
  wire next_in_sector = angle_usable &&
    (in_sector ? (sect_dist <= {2'b00, oper_angle} + `DPOC_HYST_DEG) : (sect_dist <= {2'b00, oper_angle}));

  // Sector flag with hysteresis; lost voltage with no memory gives no decision.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_sector <= 1'b0;
    end else begin
      in_sector <= next_in_sector;
    end
  end

  // Operating mode; the combinational direction path keeps directional pickup well inside its limit.
  // A VT failure without the non-directional option acts exactly like the block input.
  wire enabled = (op != `DPOC_OP_OFF) && !function_block_in_i && !(vt_failure_in_i && !vt_nondir);
  wire nondir_now = (dir == `DPOC_DIR_NONDIR) || vt_failure_in_i || switch_onto_fault_in_i;
  wire dir_ok = nondir_now || next_in_sector;
  wire over_a = phase_a_current_i > {4'h0, start_pct};
  wire over_b = phase_b_current_i > {4'h0, start_pct};
  wire over_c = phase_c_current_i > {4'h0, start_pct};
  wire [15:0] max_i = (phase_a_current_i > phase_b_current_i) ?
    ((phase_a_current_i > phase_c_current_i) ? phase_a_current_i : phase_c_current_i) :
    ((phase_b_current_i > phase_c_current_i) ? phase_b_current_i : phase_c_current_i);
  wire [2:0] next_starts = (enabled && dir_ok) ? {over_c, over_b, over_a} : 3'b000;
  wire started = next_starts != 3'b000;

  // Inverse delay in ms: multiplier (hundredths) times a simple start/excess ratio, floored.
  // Limitation: a simplified inverse law stands in for the standard curve shapes; the floor still applies.
  wire [15:0] excess = max_i - {4'h0, start_pct};
  wire [31:0] inv_raw = ({21'h000000, tms} * {20'h00000, start_pct}) / ({16'h0000, excess} + 32'h00000001);
  wire [15:0] inv_ms = (inv_raw[31:16] != 16'h0000) ? `DPOC_MS_MAX :
    ((inv_raw[15:0] < min_ms) ? min_ms : inv_raw[15:0]);
  wire [15:0] delay_ms = switch_onto_fault_in_i ? sotf_ms : ((op == `DPOC_OP_DT) ? def_ms : inv_ms);
  // Progress is accumulated as delay-normalised units so curve changes mid-fault stay consistent.
  wire [31:0] full_scale = 32'h00010000;
  wire [31:0] step = full_scale / {16'h0000, (delay_ms == 16'h0000 ? 16'h0001 : delay_ms)};

  // Timer state machine; the count starts in the first cycle the fault is seen.
  // A fault that clears while running abandons the trip; the accumulator decides what is kept.
  always @* begin
    case (state)
      ST_IDLE: next_state = started ? ST_RUN : ST_IDLE;
      ST_RUN: next_state = !started ? ST_IDLE : ((accum >= full_scale) ? ST_TRIP : ST_RUN);
      ST_TRIP: next_state = started ? ST_TRIP : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Accumulator: integrates while started, decays linearly over the reset time for IEC curves,
  // and clears at once otherwise. The decay keeps a quick refault faster than the first one.
  // The decay divides by the remaining time only while that time is nonzero, so it never divides by zero.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      accum <= 32'h00000000;
      decay_ms <= 16'h0000;
    end else begin
      state <= next_state;
      if (!enabled) begin
        accum <= 32'h00000000;
      end else if (started) begin
        decay_ms <= rst_ms;
        if (ms_tick && accum < full_scale) begin
          accum <= accum + step;
        end
      end else if (is_iec && op != `DPOC_OP_DT) begin
        if (ms_tick && decay_ms != 16'h0000) begin
          decay_ms <= decay_ms - 16'h0001;
          accum <= accum - accum / {16'h0000, decay_ms};
        end else if (decay_ms == 16'h0000) begin
          accum <= 32'h00000000;
        end
      end else begin
        accum <= 32'h00000000;
      end
    end
  end

  // Output flags and change events; an event pulses for one cycle on each change, and its value carries the new output levels.
  // Outputs and events share one registered source, so they can never disagree by a cycle.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_a_start_out_o <= 1'b0;
      phase_b_start_out_o <= 1'b0;
      phase_c_start_out_o <= 1'b0;
      general_start_out_o <= 1'b0;
      general_trip_out_o <= 1'b0;
      prev_out <= 5'h00;
      event_o <= 5'h00;
      event_value_o <= 5'h00;
    end else begin
      phase_a_start_out_o <= next_starts[0];
      phase_b_start_out_o <= next_starts[1];
      phase_c_start_out_o <= next_starts[2];
      general_start_out_o <= started;
      general_trip_out_o <= (next_state == ST_TRIP) && enabled;
      prev_out <= {(next_state == ST_TRIP) && enabled, started, next_starts};
      event_o <= prev_out ^ {(next_state == ST_TRIP) && enabled, started, next_starts};
      event_value_o <= {(next_state == ST_TRIP) && enabled, started, next_starts};
    end
  end

  // Sticky event flags; a new change wins over a write-one-to-clear in the same cycle.
  // Losing a change to a clear would hide a start from software, which is worse than a stale flag.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      evt_sticky <= 5'h00;
    end else begin
      evt_sticky <= (evt_sticky & ~((apb_wr && paddr_i == `DPOC_EVT_ADDR) ? pwdata_i[4:0] : 5'h00)) | event_o;
    end
  end

  // Reads have no side effect.
  wire unused_rd = apb_rd;

endmodule // dpoc_core

// ### dv/dpoc_core_monitor.sv
// Concurrent checks on the output ports of the directional overcurrent block.
// Assumes it is bound to dpoc_core and sees its clock, reset and port values.
`timescale 1ns/1ns
module dpoc_core_monitor (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [15:0] phase_a_current_i,
  input wire function_block_in_i,
  input wire phase_a_start_out_o,
  input wire phase_b_start_out_o,
  input wire phase_c_start_out_o,
  input wire general_start_out_o,
  input wire general_trip_out_o,
  input wire [4:0] event_o,
  input wire [4:0] event_value_o
);
  // The block has one clock domain, so clock and reset are given once.
  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Outputs gathered in event bit order.
  wire [4:0] outs = {general_trip_out_o, general_start_out_o, phase_c_start_out_o,
                     phase_b_start_out_o, phase_a_start_out_o};

  chk_gen_any: assert property (general_start_out_o == (|outs[2:0]))
    else $error("general start differs from the phase starts");
  chk_block_clear: assert property (function_block_in_i |=> (outs == 5'h00))
    else $error("outputs still set one cycle after block");
  chk_evt_mask: assert property (event_o == (outs ^ $past(outs)))
    else $error("event mask does not match output changes");
  chk_evt_value: assert property ((event_o != 5'h00) |-> ((event_value_o & event_o) == (outs & event_o)))
    else $error("event value differs from new output level");
  chk_start_current: assert property ($rose(phase_a_start_out_o) |-> $past(phase_a_current_i) > 16'h000a)
    else $error("phase a started below the lowest threshold");
  chk_start_unblocked: assert property ($rose(general_start_out_o) |-> !$past(function_block_in_i))
    else $error("start rose while blocked");
  chk_trip_started: assert property ($rose(general_trip_out_o) |-> $past(general_start_out_o))
    else $error("trip rose without a start");
  chk_trip_unblocked: assert property ($rose(general_trip_out_o) |-> !$past(function_block_in_i))
    else $error("trip rose while blocked");
endmodule // dpoc_core_monitor

// ### dv/dpoc_field_model.sv
// Model of the measurement chain and user logic that feed the overcurrent block.
// Assumes the caller invokes its tasks from a process synchronous to core_clk_i.
`timescale 1ns/1ns
module dpoc_field_model (
  input wire core_clk_i,
  output logic [15:0] phase_a_current_o,
  output logic [15:0] phase_b_current_o,
  output logic [15:0] phase_c_current_o,
  output logic [8:0] loop_angle_o,
  output logic loop_valid_o,
  output logic volt_present_o,
  output logic block_o,
  output logic vt_fail_o,
  output logic sotf_o
);
  // Healthy voltage and a valid loop until a scenario says otherwise.
  initial begin
    phase_a_current_o = 16'h0000;
    phase_b_current_o = 16'h0000;
    phase_c_current_o = 16'h0000;
    loop_angle_o = 9'h000;
    loop_valid_o = 1'b1;
    volt_present_o = 1'b1;
    block_o = 1'b0;
    vt_fail_o = 1'b0;
    sotf_o = 1'b0;
  end

  // Currents change just after an edge, as a periodic measurement would.
  task automatic set_current(input logic [1:0] ph, input logic [15:0] v);
    @(posedge core_clk_i);
    if (ph == 2'h0) phase_a_current_o <= v;
    else if (ph == 2'h1) phase_b_current_o <= v;
    else phase_c_current_o <= v;
  endtask

  task automatic set_loop(input logic [8:0] ang);
    @(posedge core_clk_i);
    loop_angle_o <= ang;
  endtask

  // Measurement quality; without voltage the direction rests on the stored memory.
  task automatic set_meas(input logic valid, input logic volt);
    @(posedge core_clk_i);
    loop_valid_o <= valid;
    volt_present_o <= volt;
  endtask

  // User logic levels; the block level is held until changed again.
  task automatic set_flags(input logic blk, input logic vt, input logic sotf);
    @(posedge core_clk_i);
    block_o <= blk;
    vt_fail_o <= vt;
    sotf_o <= sotf;
  endtask
endmodule // dpoc_field_model

// ### dv/dpoc_core_tb.sv
// Self-checking bench for the directional overcurrent block: settings over APB, starts and events.
// Assumes the field model drives all measurement inputs; trip delays are too long to reach here.
`timescale 1ns/1ns
`include "dpoc_regs.vh"
module dpoc_core_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  logic last_err;
  wire [15:0] cur_a, cur_b, cur_c;
  wire [8:0] angle;
  wire lvalid, vpres, blk, vtf, sotf, st_a, st_b, st_c, gst, gtr;
  wire [4:0] evt, evt_val;
  wire [4:0] outs = {gtr, gst, st_c, st_b, st_a};
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2 core_clk = ~core_clk;

  dpoc_field_model field (.core_clk_i(core_clk), .phase_a_current_o(cur_a), .phase_b_current_o(cur_b),
    .phase_c_current_o(cur_c), .loop_angle_o(angle), .loop_valid_o(lvalid), .volt_present_o(vpres),
    .block_o(blk), .vt_fail_o(vtf), .sotf_o(sotf));

  dpoc_core dut (.core_clk_i(core_clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .phase_a_current_i(cur_a), .phase_b_current_i(cur_b), .phase_c_current_i(cur_c),
    .loop_angle_i(angle), .loop_valid_i(lvalid), .volt_present_i(vpres), .function_block_in_i(blk),
    .vt_failure_in_i(vtf), .switch_onto_fault_in_i(sotf), .phase_a_start_out_o(st_a),
    .phase_b_start_out_o(st_b), .phase_c_start_out_o(st_c), .general_start_out_o(gst),
    .general_trip_out_o(gtr), .event_o(evt), .event_value_o(evt_val));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // A hang is cut short well past the few hundred cycles the tests need.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check5(input logic [4:0] got, input logic [4:0] exp, input string what);
    check_val({27'h0, got}, {27'h0, exp}, what);
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check_val(q, exp, what);
  endtask

  // Starts are registered one cycle after their cause; three edges leave margin.
  task automatic settle_see(input logic [4:0] exp, input string what);
    repeat (3) @(posedge core_clk);
    #1;
    check5(outs, exp, what);
  endtask

  task automatic t_regs;
    rd_chk(`DPOC_CTRL_ADDR, 32'h10, "ctrl reset");
    rd_chk(`DPOC_ANGLE_ADDR, 32'h3c3c, "angle reset");
    rd_chk(`DPOC_START_ADDR, 32'hc8, "start reset");
    rd_chk(`DPOC_TMS_ADDR, 32'h64, "tms reset");
    rd_chk(`DPOC_MIN_ADDR, 32'h64, "min reset");
    rd_chk(`DPOC_DEF_ADDR, 32'h64, "dt reset");
    rd_chk(`DPOC_RST_ADDR, 32'h64, "decay reset");
    rd_chk(`DPOC_SOTF_ADDR, 32'h1e, "sotf reset");
    // Out-of-range writes clamp to the nearest limit, but a TMS word with high bits set and low 11 bits under 5 takes 5; an out-of-range op code falls back to off.
    wr(`DPOC_START_ADDR, 32'h5);
    rd_chk(`DPOC_START_ADDR, 32'ha, "start low clamp");
    wr(`DPOC_START_ADDR, 32'h1388);
    rd_chk(`DPOC_START_ADDR, 32'hfa0, "start high clamp");
    wr(`DPOC_ANGLE_ADDR, 32'h5a9c);
    rd_chk(`DPOC_ANGLE_ADDR, 32'h55a6, "angle clamp");
    wr(`DPOC_TMS_ADDR, 32'h1);
    rd_chk(`DPOC_TMS_ADDR, 32'h5, "tms clamp");
    wr(`DPOC_MIN_ADDR, 32'ha);
    rd_chk(`DPOC_MIN_ADDR, 32'h1e, "min clamp");
    wr(`DPOC_DEF_ADDR, 32'ha);
    rd_chk(`DPOC_DEF_ADDR, 32'h1e, "dt clamp");
    wr(`DPOC_RST_ADDR, 32'ha);
    rd_chk(`DPOC_RST_ADDR, 32'h3c, "decay clamp");
    wr(12'h040, 32'hffffffff);
    rd_chk(12'h040, 32'h0, "unmapped");
    check_val({31'h0, last_err}, 32'h0, "no slave error");
    wr(`DPOC_CTRL_ADDR, 32'h0f);
    rd_chk(`DPOC_CTRL_ADDR, 32'h0, "op code clamp");
    wr(`DPOC_START_ADDR, 32'hc8);
    wr(`DPOC_ANGLE_ADDR, 32'h3c3c);
    $display("test regs done");
  endtask

  // Threshold boundary, each phase, and on and off events in the exact cycle.
  task automatic t_phases;
    logic [4:0] m;
    field.set_current(2'h0, 16'd300);
    settle_see(5'h00, "op off");
    field.set_current(2'h0, 16'd0);
    wr(`DPOC_CTRL_ADDR, 32'h01);
    for (int ph = 0; ph < 3; ph++) begin
      m = 5'h08 | (5'h01 << ph);
      field.set_current(ph[1:0], 16'd200);
      settle_see(5'h00, "at threshold");
      field.set_current(ph[1:0], 16'd201);
      @(posedge core_clk);
      #1;
      check5(outs, m, "phase start");
      check5(evt, m, "on event");
      check5(evt_val, m, "on value");
      field.set_current(ph[1:0], 16'd0);
      @(posedge core_clk);
      #1;
      check5(evt, m, "off event");
      check5(evt_val, 5'h00, "off value");
    end
    rd_chk(`DPOC_EVT_ADDR, 32'h0f, "sticky events");
    wr(`DPOC_EVT_ADDR, 32'h1f);
    rd_chk(`DPOC_EVT_ADDR, 32'h0, "events cleared");
    $display("test phases done");
  endtask

  // Forward sector 0..120 degrees, its 10 degree hysteresis, then the mirrored sector.
  task automatic t_direction;
    wr(`DPOC_CTRL_ADDR, 32'h11);
    field.set_loop(9'd90);
    field.set_current(2'h0, 16'd300);
    settle_see(5'h09, "inside sector");
    field.set_loop(9'd125);
    settle_see(5'h09, "within hysteresis");
    field.set_loop(9'd135);
    settle_see(5'h00, "beyond hysteresis");
    field.set_loop(9'h1e2);
    settle_see(5'h00, "outside sector");
    wr(`DPOC_CTRL_ADDR, 32'h21);
    field.set_loop(9'h188);
    settle_see(5'h09, "backward inside");
    field.set_loop(9'd90);
    settle_see(5'h00, "backward outside");
    wr(`DPOC_CTRL_ADDR, 32'h11);
    field.set_loop(9'd90);
    settle_see(5'h09, "forward again");
    field.set_meas(1'b1, 1'b0);
    settle_see(5'h09, "voltage memory");
    rd_chk(`DPOC_STAT_ADDR, 32'h189, "status with memory");
    field.set_meas(1'b0, 1'b0);
    settle_see(5'h00, "no decision");
    field.set_meas(1'b1, 1'b1);
    $display("test direction done");
  endtask

  // VT failure, switch onto fault and block, with phase a current above start.
  task automatic t_inputs;
    wr(`DPOC_CTRL_ADDR, 32'h11);
    field.set_flags(1'b0, 1'b1, 1'b0);
    settle_see(5'h00, "vt fail blocks");
    wr(`DPOC_CTRL_ADDR, 32'h51);
    field.set_loop(9'h1e2);
    settle_see(5'h09, "vt fail nondir");
    field.set_flags(1'b0, 1'b0, 1'b1);
    settle_see(5'h09, "sotf ignores direction");
    field.set_flags(1'b0, 1'b0, 1'b0);
    settle_see(5'h00, "direction again");
    wr(`DPOC_CTRL_ADDR, 32'h01);
    settle_see(5'h09, "nondir start");
    rd_chk(`DPOC_STAT_ADDR, 32'h89, "status nondir");
    field.set_flags(1'b1, 1'b0, 1'b0);
    settle_see(5'h00, "blocked");
    field.set_flags(1'b0, 1'b0, 1'b0);
    settle_see(5'h09, "unblocked");
    wr(`DPOC_CTRL_ADDR, 32'h02);
    settle_see(5'h09, "inverse start");
    field.set_current(2'h0, 16'd0);
    $display("test inputs done");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_phases();
    t_direction();
    t_inputs();
    end_sim();
  end
endmodule // dpoc_core_tb

bind dpoc_core dpoc_core_monitor mon (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
  .phase_a_current_i(phase_a_current_i), .function_block_in_i(function_block_in_i),
  .phase_a_start_out_o(phase_a_start_out_o), .phase_b_start_out_o(phase_b_start_out_o),
  .phase_c_start_out_o(phase_c_start_out_o), .general_start_out_o(general_start_out_o),
  .general_trip_out_o(general_trip_out_o), .event_o(event_o), .event_value_o(event_value_o));
